//--- rtl/usc_top.sv
// Serial port clock generation and frame engine with AXI4-Lite registers.
// Assumes a single core_clk; serial inputs synchronous to it.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "usc_params.svh"
module usc_top #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial lines
  input wire logic rxd,
  output logic txd,
  // Transfer clock pin
  input wire logic xck_i,
  output logic xck_o,
  output logic xck_oe
);

  // ==================================================
  // Register state
  // Named copy so that single reset bits can be selected from it
  localparam logic [7:0] RST_A = `USC_RST_A;
  logic dbl_q, txc_q, rxc_q, fe_q, pe_q;
  logic rxen_q, txen_q, csz2_q, rx9_q, tx9_q;
  logic [7:0] csc_q;
  logic [DIV_W-1:0] div_q;
  logic xdir_q;
  logic [7:0] rxbuf_q;
  logic [8:0] txb_q;
  logic txb_full_q;

  // Bus channel state
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ==================================================
  // Write channel acceptance, either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;

  logic wr_fire, rd_fire;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;

  // Write decode; byte lane 0 carries every register
  logic wr_en, sel_data, sel_a, sel_b, sel_c, sel_lo, sel_hi, sel_x, wr_hit;
  assign wr_en = wr_fire && w_lane_q;
  assign sel_data = wr_en && (aw_addr_q == `USC_OFF_DATA);
  assign sel_a = wr_en && (aw_addr_q == `USC_OFF_CSA);
  assign sel_b = wr_en && (aw_addr_q == `USC_OFF_CSB);
  assign sel_c = wr_en && (aw_addr_q == `USC_OFF_CSC);
  assign sel_lo = wr_en && (aw_addr_q == `USC_OFF_BAUD_LO);
  assign sel_hi = wr_en && (aw_addr_q == `USC_OFF_BAUD_HI);
  assign sel_x = wr_en && (aw_addr_q == `USC_OFF_XDIR);
  assign wr_hit = (aw_addr_q == `USC_OFF_DATA) || (aw_addr_q == `USC_OFF_CSA)
    || (aw_addr_q == `USC_OFF_CSB) || (aw_addr_q == `USC_OFF_CSC)
    || (aw_addr_q == `USC_OFF_BAUD_LO) || (aw_addr_q == `USC_OFF_BAUD_HI)
    || (aw_addr_q == `USC_OFF_XDIR);

  // Bus handshake registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      bresp_q <= `USC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==================================================
  // Read data multiplexer
  logic [7:0] rd_a, rd_b;
  logic [31:0] rd_word;
  logic rd_hit, rd_data;
  always_comb begin
    rd_a = 8'h00;
    rd_a[`USC_A_RXC] = rxc_q;
    rd_a[`USC_A_TXC] = txc_q;
    rd_a[`USC_A_TXE] = !txb_full_q;
    rd_a[`USC_A_FE] = fe_q;
    rd_a[`USC_A_PE] = pe_q;
    rd_a[`USC_A_DBL] = dbl_q;
    rd_b = 8'h00;
    rd_b[`USC_B_RXEN] = rxen_q;
    rd_b[`USC_B_TXEN] = txen_q;
    rd_b[`USC_B_CSZ2] = csz2_q;
    rd_b[`USC_B_RX9] = rx9_q;
    rd_b[`USC_B_TX9] = tx9_q;
  end
  assign rd_data = (s_axi_araddr == `USC_OFF_DATA);
  assign rd_hit = rd_data || (s_axi_araddr == `USC_OFF_CSA)
    || (s_axi_araddr == `USC_OFF_CSB) || (s_axi_araddr == `USC_OFF_CSC)
    || (s_axi_araddr == `USC_OFF_BAUD_LO) || (s_axi_araddr == `USC_OFF_BAUD_HI)
    || (s_axi_araddr == `USC_OFF_XDIR);
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_data) begin
      rd_word[7:0] = rxbuf_q;
    end else if (s_axi_araddr == `USC_OFF_CSA) begin
      rd_word[7:0] = rd_a;
    end else if (s_axi_araddr == `USC_OFF_CSB) begin
      rd_word[7:0] = rd_b;
    end else if (s_axi_araddr == `USC_OFF_CSC) begin
      rd_word[7:0] = csc_q;
    end else if (s_axi_araddr == `USC_OFF_BAUD_LO) begin
      rd_word[7:0] = div_q[7:0];
    end else if (s_axi_araddr == `USC_OFF_BAUD_HI) begin
      rd_word[DIV_W-9:0] = div_q[DIV_W-1:8];
    end else if (s_axi_araddr == `USC_OFF_XDIR) begin
      rd_word[0] = xdir_q;
    end
  end

  // Read channel; data read pops the receive flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `USC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==================================================
  // Frame format decode
  usc_pkg::usc_fmt_s fmt;
  logic [2:0] csz;
  assign csz = {csz2_q, csc_q[`USC_C_CSZ_HI:`USC_C_CSZ_LO]};
  assign fmt.sync = csc_q[`USC_C_SYNC];
  assign fmt.cpol = csc_q[`USC_C_CPOL];
  assign fmt.par_en = (csc_q[`USC_C_PM_HI:`USC_C_PM_LO] == `USC_PM_EVEN)
    || (csc_q[`USC_C_PM_HI:`USC_C_PM_LO] == `USC_PM_ODD);
  assign fmt.par_odd = (csc_q[`USC_C_PM_HI:`USC_C_PM_LO] == `USC_PM_ODD);
  assign fmt.two_stop = csc_q[`USC_C_SBS];
  // Size 7 is nine bits; 4 to 6 fall back to eight
  assign fmt.nbits = (csz == `USC_CSZ_NINE) ? 4'd9 : (csz[2] ? 4'd8 : {2'b01, csz[1:0]} + 4'd1);

  // ==================================================
  // Baud generator and transfer clock
  logic tick, dbl_eff, master, slave;
  logic [4:0] ovs, pre_q;
  usc_pkg::usc_edge_s sedge, xedge;

  // Twelve bit divisor from two registers
  usc_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .divisor(div_q),
    .reload(sel_lo),
    .tick(tick)
  );

  usc_xck_sync u_xsync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .xck_i(xck_i),
    .edges(sedge)
  );

  // Double speed ignored in sync mode
  assign dbl_eff = dbl_q && !fmt.sync;
  // Pin direction picks master or slave
  assign master = fmt.sync && xdir_q;
  assign slave = fmt.sync && !xdir_q;
  assign ovs = fmt.sync ? `USC_OVS_SYNC : (dbl_eff ? `USC_OVS_DOUBLE : `USC_OVS_NORMAL);

  // Tick prescaler; in master mode its low bit is the clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 5'd0;
    end else if (tick) begin
      pre_q <= (pre_q >= ovs - 5'd1) ? 5'd0 : pre_q + 5'd1;
    end
  end

  // Drive the pin only as master
  assign xck_oe = master;
  assign xck_o = master & pre_q[0];
  assign xedge.rise = master ? (tick && !pre_q[0]) : (slave && sedge.rise);
  assign xedge.fall = master ? (tick && pre_q[0]) : (slave && sedge.fall);

  logic chg_evt, smp_evt, tx_step;
  assign chg_evt = fmt.cpol ? xedge.fall : xedge.rise;
  assign smp_evt = fmt.cpol ? xedge.rise : xedge.fall;
  assign tx_step = fmt.sync ? chg_evt : (tick && pre_q == ovs - 5'd1);

  // ==================================================
  // Transmitter
  logic [12:0] tx_sh_q, tx_frame;
  logic [3:0] tx_left_q, tx_total;
  logic tx_busy_q, tx_load, tx_end;

  always_comb begin
    tx_frame = 13'h1fff;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(fmt.nbits)) begin
        tx_frame[i+1] = txb_q[i];
      end
    end
    if (fmt.par_en) begin
      tx_frame[fmt.nbits+4'd1] = ^(txb_q & ~(9'h1ff << fmt.nbits)) ^ fmt.par_odd;
    end
  end
  assign tx_total = 4'd2 + fmt.nbits + {3'd0, fmt.par_en} + {3'd0, fmt.two_stop};
  assign tx_end = tx_step && tx_busy_q && (tx_left_q == 4'd1);
  assign tx_load = tx_step && (!tx_busy_q || tx_left_q == 4'd1) && txb_full_q && txen_q;

  // Back to back frames or idle high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 13'h1fff;
      tx_left_q <= 4'd0;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= tx_frame;
      tx_left_q <= tx_total;
    end else if (tx_end) begin
      tx_busy_q <= 1'b0;
    end else if (tx_step && tx_busy_q) begin
      tx_sh_q <= {1'b1, tx_sh_q[12:1]};
      tx_left_q <= tx_left_q - 4'd1;
    end
  end
  assign txd = tx_busy_q ? tx_sh_q[0] : 1'b1;

  // ==================================================
  // Receiver
  usc_pkg::usc_rx_e rx_st_q;
  logic [4:0] rx_ph_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_dat_q;
  logic rx_pbad_q, rx_samp, rx_done, rx_fe;
  logic [8:0] rx_dat_d;

  // Sample count follows the ticks-per-bit setting
  assign rx_samp = (rx_st_q == usc_pkg::RX_BITS)
    && (fmt.sync ? smp_evt : (tick && rx_ph_q == ovs - 5'd1));
  // Only the first stop bit is checked
  assign rx_done = rx_samp && (rx_idx_q == fmt.nbits + {3'd0, fmt.par_en});
  assign rx_fe = !rxd;
  always_comb begin
    rx_dat_d = rx_dat_q;
    if (rx_idx_q < 4'd9) begin
      rx_dat_d[rx_idx_q] = rxd;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= usc_pkg::RX_IDLE;
      rx_ph_q <= 5'd0;
      rx_idx_q <= 4'd0;
      rx_dat_q <= 9'h000;
      rx_pbad_q <= 1'b0;
    end else begin
      case (rx_st_q)
        usc_pkg::RX_IDLE: begin
          rx_ph_q <= 5'd0;
          rx_idx_q <= 4'd0;
          rx_dat_q <= 9'h000;
          if (rxen_q && !rxd) begin
            if (fmt.sync && smp_evt) begin
              rx_st_q <= usc_pkg::RX_BITS;
            end else if (!fmt.sync && tick) begin
              rx_st_q <= usc_pkg::RX_START;
            end
          end
        end
        usc_pkg::RX_START: begin
          // Half a bit later the start bit must still be low
          if (tick) begin
            rx_ph_q <= rx_ph_q + 5'd1;
            if (rx_ph_q == (ovs >> 1) - 5'd1) begin
              rx_ph_q <= 5'd0;
              rx_st_q <= rxd ? usc_pkg::RX_IDLE : usc_pkg::RX_BITS;
            end
          end
        end
        usc_pkg::RX_BITS: begin
          if (tick) begin
            rx_ph_q <= (rx_ph_q == ovs - 5'd1) ? 5'd0 : rx_ph_q + 5'd1;
          end
          if (rx_samp) begin
            rx_idx_q <= rx_idx_q + 4'd1;
            if (rx_idx_q < fmt.nbits) begin
              rx_dat_q <= rx_dat_d;
            end else if (!rx_done) begin
              rx_pbad_q <= (^rx_dat_q) ^ fmt.par_odd ^ rxd;
            end
          end
          if (rx_done || !rxen_q) begin
            rx_st_q <= usc_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= usc_pkg::RX_IDLE;
      endcase
    end
  end

  // ==================================================
  // Control registers and flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dbl_q <= RST_A[`USC_A_DBL];
      {rxen_q, txen_q, csz2_q, tx9_q} <= 4'h0;
      csc_q <= `USC_RST_C;
      div_q <= `USC_RST_DIV;
      xdir_q <= 1'b0;
      txb_q <= 9'h000;
      txb_full_q <= 1'b0;
    end else begin
      if (sel_a) dbl_q <= w_byte_q[`USC_A_DBL];
      if (sel_b) begin
        rxen_q <= w_byte_q[`USC_B_RXEN];
        txen_q <= w_byte_q[`USC_B_TXEN];
        csz2_q <= w_byte_q[`USC_B_CSZ2];
        tx9_q <= w_byte_q[`USC_B_TX9];
      end
      if (sel_c) csc_q <= w_byte_q;
      if (sel_lo) div_q[7:0] <= w_byte_q;
      if (sel_hi) div_q[DIV_W-1:8] <= w_byte_q[DIV_W-9:0];
      if (sel_x) xdir_q <= w_byte_q[0];
      // A write to a full buffer is dropped
      if (tx_load) begin
        txb_full_q <= 1'b0;
      end else if (sel_data && !txb_full_q) begin
        txb_full_q <= 1'b1;
        txb_q <= {tx9_q, w_byte_q};
      end
    end
  end

  // Completion flags; a set beats a clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txc_q <= RST_A[`USC_A_TXC];
      rxc_q <= RST_A[`USC_A_RXC];
      fe_q <= 1'b0;
      pe_q <= 1'b0;
      rx9_q <= 1'b0;
      rxbuf_q <= 8'h00;
    end else begin
      if (tx_end && !tx_load) begin
        txc_q <= 1'b1;
      end else if (sel_a && w_byte_q[`USC_A_TXC]) begin
        txc_q <= 1'b0;
      end
      if (rx_done) begin
        rxc_q <= 1'b1;
        rxbuf_q <= rx_dat_q[7:0];
        rx9_q <= rx_dat_q[8];
        fe_q <= rx_fe;
        pe_q <= fmt.par_en && rx_pbad_q;
      end else if (rd_fire && rd_data) begin
        rxc_q <= 1'b0;
      end
    end
  end

endmodule

//--- rtl/usc_params.svh
// Constants for the serial port clock and frame block: offsets, field
// positions, reset values and clock ratios.
// Assumes inclusion by bare name from the design files.
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// ==================================================
// Register byte offsets
`define USC_OFF_DATA 8'h00
`define USC_OFF_CSA 8'h04
`define USC_OFF_CSB 8'h08
`define USC_OFF_CSC 8'h0c
`define USC_OFF_BAUD_LO 8'h10
`define USC_OFF_BAUD_HI 8'h14
`define USC_OFF_XDIR 8'h18

// ==================================================
// Field positions, control and status A
`define USC_A_RXC 7
`define USC_A_TXC 6
`define USC_A_TXE 5
`define USC_A_FE 4
`define USC_A_PE 2
`define USC_A_DBL 1
// Control and status B
`define USC_B_RXEN 4
`define USC_B_TXEN 3
`define USC_B_CSZ2 2
`define USC_B_RX9 1
`define USC_B_TX9 0
// Control and status C
`define USC_C_SYNC 6
`define USC_C_PM_HI 5
`define USC_C_PM_LO 4
`define USC_C_SBS 3
`define USC_C_CSZ_HI 2
`define USC_C_CSZ_LO 1
`define USC_C_CPOL 0

// ==================================================
// Reset values
`define USC_RST_A 8'h20
`define USC_RST_B 8'h00
`define USC_RST_C 8'h06
`define USC_RST_DIV 12'h000

// ==================================================
// Ticks per bit and codes
`define USC_OVS_NORMAL 5'd16
`define USC_OVS_DOUBLE 5'd8
`define USC_OVS_SYNC 5'd2
`define USC_CSZ_NINE 3'd7
`define USC_PM_EVEN 2'b10
`define USC_PM_ODD 2'b11
`define USC_RESP_OKAY 2'b00
`define USC_RESP_SLVERR 2'b10

`endif

//--- rtl/usc_pkg.sv
// Types shared by the serial port clock and frame block.
// Assumes nothing of its surroundings.
package usc_pkg;

  // ==================================================
  // Receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} usc_rx_e;

  // ==================================================
  // Decoded frame format, shared by both directions
  typedef struct packed {
    logic sync;
    logic cpol;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic [3:0] nbits;
  } usc_fmt_s;

  // Transfer clock edge events, one cycle each
  typedef struct packed {
    logic rise;
    logic fall;
  } usc_edge_s;

endpackage

//--- rtl/usc_baud_gen.sv
// Baud down-counter giving one tick per divisor+1 clocks.
// Assumes divisor is stable except around a reload pulse.
`timescale 1ns/1ns
module usc_baud_gen #(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic [DIV_W-1:0] divisor,
  input wire logic reload,
  // Tick out
  output logic tick
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  // ==================================================
  // Reload at zero or low write
  assign tick = (cnt_q == '0);
  assign cnt_d = (reload || tick) ? divisor : cnt_q - 1'b1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

//--- rtl/usc_xck_sync.sv
// Synchroniser and edge detector for an external transfer clock.
// Assumes the clock is below a quarter of core_clk.
`timescale 1ns/1ns
module usc_xck_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pin in
  input wire logic xck_i,
  // Edge events
  output usc_pkg::usc_edge_s edges
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ==================================================
  // Synchroniser then edge detector
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= xck_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Only the second stage and its delayed copy are compared
  assign edges.rise = sync_q & ~prev_q;
  assign edges.fall = ~sync_q & prev_q;

endmodule

//--- tb/usc_sva.sv
// Port checker for the serial clock and frame block.
// Assumes binding onto usc_top.
`timescale 1ns/1ns
module usc_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins
  input wire logic txd,
  input wire logic xck_o,
  input wire logic xck_oe
);
  // ==========
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write reply dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("read reply dropped");
  a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while reply pending");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while reply pending");
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write reply late");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read reply late");
  a_xck_quiet: assert property (!xck_oe |-> !xck_o)
    else $error("clock pin driven while input");
  a_bit_min: assert property ($changed(txd) |=> $stable(txd))
    else $error("serial bit shorter than two clocks");
endmodule

bind usc_top usc_sva usc_sva_i (.core_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .txd, .xck_o, .xck_oe);

//--- tb/usc_peer.sv
// Remote serial peer: decodes txd frames, sends rxd frames, clocks slaves.
// Assumes the bench sets bit length and frame length before each frame.
`timescale 1ns/1ns
module usc_peer (
  // Clock
  input wire logic core_clk,
  // Pacing
  input wire logic [15:0] bit_clks,
  input wire logic [3:0] frm_len,
  input wire logic xck_run,
  // Serial lines
  input wire logic txd,
  output logic rxd,
  output logic xck_i
);
  logic [15:0] got_q[$];
  logic lvl_q[$];
  logic [1:0] cnt_q = 2'h0;

  // Idle line high, clock still
  initial begin
    rxd = 1'b1;
    xck_i = 1'b0;
  end

  // slave clock at an eighth of core_clk
  always @(posedge core_clk) begin
    cnt_q <= cnt_q + 2'h1;
    if (xck_run && cnt_q == 2'h3)
      xck_i <= !xck_i;
  end

  // Sample mid-bit on falling clock, away from txd updates
  always begin : rx_frames
    logic [15:0] v;
    @(negedge txd);
    lvl_q.push_back(xck_i);
    v = 16'h0;
    repeat (bit_clks / 2) @(negedge core_clk);
    for (int i = 0; i < frm_len; i++) begin
      v[i] = txd;
      repeat (bit_clks) @(negedge core_clk);
    end
    got_q.push_back(v);
  end

  // frame onto rxd, line returns high after
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rxd <= bits[i];
      repeat (bit_clks - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rxd <= 1'b1;
  endtask
endmodule

//--- tb/usart_clock_and_frame_format_test.sv
// Self-checking bench for the serial clock and frame block.
// Assumes usc_top, usc_peer and the checker are compiled alongside.
`timescale 1ns/1ns
`include "usc_params.svh"
module usart_clock_and_frame_format_test;
  logic core_clk, rst_b, rxd, txd, xck_i, xck_o, xck_oe, xck_run;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, frm_len;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] bit_clks;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  usc_top usc_top_i (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .xck_i, .xck_o, .xck_oe);
  usc_peer usc_peer_i (.core_clk, .bit_clks, .frm_len, .xck_run, .txd, .rxd, .xck_i);

  // ==========
  // Clock and hang guard, sized for about 16k cycles of traffic
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ==========
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========
  // Bus master: each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] resp;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      // Sample settled handshakes before the edge that takes them
      @(negedge core_clk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end while (!b_ok);
    s_axi_bready <= 1'b0;
    chk("bresp", resp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
    logic ar_ok, r_ok;
    logic [1:0] resp;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end while (!r_ok);
    s_axi_rready <= 1'b0;
    chk("rresp", resp, er);
  endtask

  // ==========
  // Reference frame: start in bit 0, then data, parity, stops, idle
  function automatic logic [15:0] frame(input logic [8:0] d, input int nb, input int pm,
      input int st, output int n);
    logic [15:0] v;
    v = 16'h0;
    for (int i = 0; i < nb; i++)
      v[1 + i] = d[i];
    n = nb + 1;
    if (pm >= 2) begin
      v[n] = ^(d & ((1 << nb) - 1)) ^ (pm == 3);
      n = n + 1;
    end
    for (int i = 0; i < 2 + st; i++)
      v[n + i] = 1'b1;
    n = n + 2 + st;
    return v;
  endfunction

  // One transmitted frame checked against the reference
  task automatic tx_frame(input logic [8:0] d, input int nb, input logic [1:0] pm,
      input logic st, input logic dbl, input logic sy, input logic cpol, input logic dir);
    logic [15:0] exp;
    logic [31:0] r;
    logic [2:0] cz;
    int n;
    exp = frame(d, nb, pm, st, n);
    cz = (nb == 9) ? 3'h7 : 3'(nb - 5);
    frm_len <= n[3:0];
    // format first, enables after; caller keeps dbl low in sync
    wr(`USC_OFF_CSA, {6'h10, dbl, 1'b0});
    wr(`USC_OFF_CSC, {1'b0, sy, pm, st, cz[1:0], cpol});
    wr(`USC_OFF_CSB, {5'h03, cz[2], 1'b0, d[8]});
    wr(`USC_OFF_DATA, d[7:0]);
    while (usc_peer_i.got_q.size() == 0) @(posedge core_clk);
    chk("frame bits", usc_peer_i.got_q.pop_front(), exp);
    chk("start clock level", usc_peer_i.lvl_q.pop_front() | !(sy & !dir), !cpol);
    chk("clock drive", xck_oe, sy & dir);
    rd(`USC_OFF_CSA, r);
    chk("tx done", r[6:5], 2'h3);
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [7:0] offs [6] = '{`USC_OFF_CSA, `USC_OFF_CSB, `USC_OFF_CSC, `USC_OFF_BAUD_LO,
      `USC_OFF_BAUD_HI, `USC_OFF_XDIR};
    logic [7:0] rstv [6] = '{`USC_RST_A, `USC_RST_B, `USC_RST_C, 8'h00, 8'h00, 8'h00};
    int dv [5] = '{3, 2, 256, 0, 0};
    int bc [5] = '{64, 24, 514, 8, 8};
    logic [3:0] mb [5] = '{4'h0, 4'h8, 4'h5, 4'h4, 4'h6};
    logic [31:0] r;
    logic [15:0] f;
    logic [8:0] d;
    int n;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    xck_run = 1'b0;
    bit_clks = 16'd16;
    frm_len = 4'h0;
    n = $urandom(16416);
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(offs[k], r);
      chk("reset value", r, {24'h0, rstv[k]});
    end
    wr(8'h1c, 8'h55, `USC_RESP_SLVERR);
    rd(8'h1c, r, `USC_RESP_SLVERR);
    chk("unmapped data", r, 32'h0);
    $display("test reset and map done");
    // all sizes, parity codes and stop counts
    for (int nb = 5; nb <= 9; nb++)
      for (int pm = 0; pm < 4; pm++)
        for (int st = 0; st < 2; st++)
          tx_frame(9'($urandom), nb, pm[1:0], st[0], 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test frame formats done");
    // bit time per mode and divisor
    // each frame is complete before the next reconfiguration
    for (int k = 0; k < 5; k++) begin
      wr(`USC_OFF_BAUD_HI, 8'(dv[k] >> 8));
      wr(`USC_OFF_BAUD_LO, 8'(dv[k]));
      wr(`USC_OFF_XDIR, {7'h0, mb[k][0]});
      bit_clks <= 16'(bc[k]);
      xck_run <= mb[k][2] & !mb[k][0];
      tx_frame(9'($urandom), 8, 2'h0, 1'b0, mb[k][3], mb[k][2], mb[k][1], mb[k][0]);
    end
    xck_run <= 1'b0;
    $display("test clock modes done");
    // good frame, then bad parity and stop at double speed
    for (int k = 0; k < 2; k++) begin
      d = 9'($urandom);
      wr(`USC_OFF_CSA, {6'h10, k[0], 1'b0});
      wr(`USC_OFF_CSB, 8'h18);
      wr(`USC_OFF_CSC, 8'h26);
      bit_clks <= (k == 1) ? 16'd8 : 16'd16;
      f = frame(d, 8, 2, 0, n) ^ ((k == 1) ? 16'h0600 : 16'h0);
      usc_peer_i.send(f, n);
      repeat (4) @(posedge core_clk);
      rd(`USC_OFF_CSA, r);
      chk("rx status", {r[7], r[4], r[2]}, {1'b1, k[0], k[0]});
      rd(`USC_OFF_DATA, r);
      chk("rx data", r, {24'h0, d[7:0]});
      rd(`USC_OFF_CSA, r);
      chk("rx flag cleared", r[7], 1'b0);
    end
    $display("test receive done");
    test_done();
  end
endmodule
